// ==== src/rops_defines.vh ====
`ifndef ROPS_DEFINES_VH
`define ROPS_DEFINES_VH

// Per-pin behaviour codes for a special operating condition.
`define ROPS_PM_WIDTH 3
`define ROPS_PM_ACTIVE 3'h0
`define ROPS_PM_HIGH 3'h1
`define ROPS_PM_LOW 3'h2
`define ROPS_PM_FLOAT 3'h3
`define ROPS_PM_RETAIN 3'h4
`define ROPS_PM_WEAK_HIGH 3'h5

// Clock output period in processor clocks (clock output toggles every clock).
`define ROPS_CLK_PER_SYSTEM_CLOCK_OUT 2
// Reset output stays high this many clock output periods after the input is released.
`define ROPS_RST_RELEASE_CLKOUTS 2
// Mode strap is checked again this many clock output periods after the release.
`define ROPS_STRAP_LATE_CLKOUTS 4
`define ROPS_RST_RELEASE_CYCLES (`ROPS_RST_RELEASE_CLKOUTS * `ROPS_CLK_PER_SYSTEM_CLOCK_OUT)
`define ROPS_STRAP_LATE_CYCLES (`ROPS_STRAP_LATE_CLKOUTS * `ROPS_CLK_PER_SYSTEM_CLOCK_OUT)
`define ROPS_CNT_WIDTH 4

// Reset values.
`define ROPS_RESET_OUT_INIT 1'h1
`define ROPS_ENHANCED_INIT 1'h0

`endif

// ==== src/rops_sync.v ====
`default_nettype none

module rops_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // Stage one is only ever read by stage two, so metastability cannot fan out.
  always @(posedge clk) begin
    if (rst) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else if (ce) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // rops_sync

`default_nettype wire

// ==== src/rops_ctrl.v ====
`include "rops_defines.vh"
`default_nettype none

module rops_ctrl #(
  parameter NUM_PINS = 4,
  parameter [`ROPS_PM_WIDTH*NUM_PINS-1:0] HOLD_MODES = {NUM_PINS{`ROPS_PM_FLOAT}},
  parameter [`ROPS_PM_WIDTH*NUM_PINS-1:0] RESET_MODES = {NUM_PINS{`ROPS_PM_HIGH}},
  parameter [`ROPS_PM_WIDTH*NUM_PINS-1:0] IDLE_MODES = {NUM_PINS{`ROPS_PM_ACTIVE}},
  parameter [`ROPS_PM_WIDTH*NUM_PINS-1:0] PD_MODES = {NUM_PINS{`ROPS_PM_RETAIN}}
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire external_reset_in_n,
  input wire hold_ack,
  input wire idle_active,
  input wire powerdown_active,
  input wire upper_memory_select_in,
  input wire lower_memory_select_in,
  input wire mode_strap_in,
  input wire crystal_drive_in,
  input wire [7:0] core_ad_out,
  input wire core_ad_oe,
  input wire [7:0] muxed_addr_data_low_in,
  input wire [NUM_PINS-1:0] core_pin_out,
  input wire [NUM_PINS-1:0] core_pin_oe,
  output reg system_reset_out,
  output reg system_reset_oe,
  output reg system_clock_out,
  output reg system_clock_oe,
  output reg crystal_drive_out,
  output reg [7:0] muxed_addr_data_low_out,
  output reg muxed_addr_data_low_oe,
  output reg [7:0] ad_in_sampled,
  output reg [NUM_PINS-1:0] pin_out,
  output reg [NUM_PINS-1:0] pin_oe,
  output reg [NUM_PINS-1:0] pin_weak_high,
  output reg reset_input_low,
  output reg pin_float_test_mode,
  output reg enhanced_mode
);

  // Returns {weak_high, oe, out} for one pin under one behaviour code.
  function [2:0] rops_apply;
    input [`ROPS_PM_WIDTH-1:0] code;
    input act_out;
    input act_oe;
    input cur_out;
    input cur_oe;
    begin
      case (code)
        `ROPS_PM_ACTIVE: rops_apply = {1'b0, act_oe, act_out};
        `ROPS_PM_HIGH: rops_apply = 3'h3;
        `ROPS_PM_LOW: rops_apply = 3'h2;
        `ROPS_PM_FLOAT: rops_apply = 3'h0;
        `ROPS_PM_RETAIN: rops_apply = {1'b0, cur_oe, cur_out};
        `ROPS_PM_WEAK_HIGH: rops_apply = 3'h5;
        default: rops_apply = 3'h0;
      endcase
    end
  endfunction

  // The counts are reckoned at full integer width and cut to the counter width on purpose.
  localparam integer RELEASE_CYCLES_FULL = `ROPS_RST_RELEASE_CYCLES;
  localparam integer STRAP_CYCLES_FULL = `ROPS_STRAP_LATE_CYCLES;
  localparam [`ROPS_CNT_WIDTH-1:0] RELEASE_CYCLES = RELEASE_CYCLES_FULL[`ROPS_CNT_WIDTH-1:0];
  localparam [`ROPS_CNT_WIDTH-1:0] STRAP_CYCLES = STRAP_CYCLES_FULL[`ROPS_CNT_WIDTH-1:0];

  localparam [1:0] ST_IN_RESET = 2'h0;
  localparam [1:0] ST_RELEASE = 2'h1;
  localparam [1:0] ST_STRAP_WAIT = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;

  wire reset_in_sync;
  reg reset_in_last;
  reg [1:0] state;
  reg [`ROPS_CNT_WIDTH-1:0] count;
  reg strap_early;
  wire release_edge;

  // The synchronizer starts in the reset level so nothing runs before the input is seen high.
  rops_sync #(.WIDTH(1), .INIT(1'b0)) u_reset_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(external_reset_in_n),
    .sync_out(reset_in_sync)
  );

  assign release_edge = reset_in_sync & ~reset_in_last;

  // Reset sequencing, strap capture and mode flags.
  always @(posedge clk) begin
    if (rst) begin
      reset_in_last <= 1'b0;
      state <= ST_IN_RESET;
      count <= {`ROPS_CNT_WIDTH{1'b0}};
      strap_early <= 1'b0;
      system_reset_out <= `ROPS_RESET_OUT_INIT;
      reset_input_low <= 1'b1;
      pin_float_test_mode <= 1'b0;
      enhanced_mode <= `ROPS_ENHANCED_INIT;
    end else if (ce) begin
      reset_in_last <= reset_in_sync;
      reset_input_low <= ~reset_in_sync;
      if (!reset_in_sync) begin
        // Any new reset ends the test mode; strap_early and enhanced_mode keep their values.
        state <= ST_IN_RESET;
        count <= {`ROPS_CNT_WIDTH{1'b0}};
        system_reset_out <= 1'b1;
        pin_float_test_mode <= 1'b0;
      end else begin
        case (state)
          ST_IN_RESET: begin
            if (release_edge) begin
              strap_early <= mode_strap_in;
              pin_float_test_mode <= ~upper_memory_select_in & ~lower_memory_select_in;
              count <= {{(`ROPS_CNT_WIDTH-1){1'b0}}, 1'b1};
              state <= ST_RELEASE;
            end
          end
          ST_RELEASE: begin
            count <= count + {{(`ROPS_CNT_WIDTH-1){1'b0}}, 1'b1};
            if (count == RELEASE_CYCLES) begin
              system_reset_out <= 1'b0;
              state <= ST_STRAP_WAIT;
            end
          end
          ST_STRAP_WAIT: begin
            count <= count + {{(`ROPS_CNT_WIDTH-1){1'b0}}, 1'b1};
            if (count == STRAP_CYCLES) begin
              enhanced_mode <= strap_early & ~mode_strap_in;
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            state <= ST_RUN;
          end
          default: begin
            state <= ST_IN_RESET;
          end
        endcase
      end
    end
  end

  // Pin state selection. Test mode outranks reset, reset outranks hold, then powerdown, then idle.
  reg [2:0] pin_sel;
  reg [`ROPS_PM_WIDTH-1:0] pin_code;
  reg [NUM_PINS-1:0] next_pin_out;
  reg [NUM_PINS-1:0] next_pin_oe;
  reg [NUM_PINS-1:0] next_pin_weak;
  integer i;

  always @* begin
    pin_sel = 3'h0;
    pin_code = `ROPS_PM_ACTIVE;
    next_pin_out = {NUM_PINS{1'b0}};
    next_pin_oe = {NUM_PINS{1'b0}};
    next_pin_weak = {NUM_PINS{1'b0}};
    for (i = 0; i < NUM_PINS; i = i + 1) begin
      if (pin_float_test_mode) begin
        pin_code = `ROPS_PM_FLOAT;
      end else if (system_reset_out) begin
        pin_code = RESET_MODES[i*`ROPS_PM_WIDTH +: `ROPS_PM_WIDTH];
      end else if (hold_ack) begin
        pin_code = HOLD_MODES[i*`ROPS_PM_WIDTH +: `ROPS_PM_WIDTH];
      end else if (powerdown_active) begin
        pin_code = PD_MODES[i*`ROPS_PM_WIDTH +: `ROPS_PM_WIDTH];
      end else if (idle_active) begin
        pin_code = IDLE_MODES[i*`ROPS_PM_WIDTH +: `ROPS_PM_WIDTH];
      end else begin
        pin_code = `ROPS_PM_ACTIVE;
      end
      pin_sel = rops_apply(pin_code, core_pin_out[i], core_pin_oe[i], pin_out[i], pin_oe[i]);
      next_pin_out[i] = pin_sel[0];
      next_pin_oe[i] = pin_sel[1];
      next_pin_weak[i] = pin_sel[2];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pin_out <= {NUM_PINS{1'b0}};
      pin_oe <= {NUM_PINS{1'b0}};
      pin_weak_high <= {NUM_PINS{1'b0}};
      system_reset_oe <= 1'b1;
      system_clock_out <= 1'b0;
      system_clock_oe <= 1'b1;
      crystal_drive_out <= 1'b0;
      muxed_addr_data_low_out <= 8'h00;
      muxed_addr_data_low_oe <= 1'b0;
      ad_in_sampled <= 8'h00;
    end else if (ce) begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_weak_high <= next_pin_weak;
      // The reset output is never floated in hold or reset; only test mode releases it.
      system_reset_oe <= ~pin_float_test_mode;
      // The clock output keeps running through reset and hold.
      system_clock_out <= ~system_clock_out;
      system_clock_oe <= ~pin_float_test_mode;
      // The crystal drive keeps working even in test mode, so the oscillator never stalls.
      crystal_drive_out <= crystal_drive_in;
      muxed_addr_data_low_out <= core_ad_out;
      muxed_addr_data_low_oe <= core_ad_oe & ~hold_ack & ~reset_input_low & ~system_reset_out
                                & ~pin_float_test_mode;
      // Sampled muxed_addr_data_low_in per clock with no synchronizer; the driver must meet setup to the clock output.
      ad_in_sampled <= muxed_addr_data_low_in;
    end
  end

endmodule // rops_ctrl

`default_nettype wire

// ==== verif/rops_ctrl_sva.sv ====
`default_nettype none
module rops_ctrl_sva #(
  parameter NUM_PINS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hold_ack,
  input wire logic upper_memory_select_in,
  input wire logic lower_memory_select_in,
  input wire logic mode_strap_in,
  input wire logic crystal_drive_in,
  input wire logic crystal_drive_out,
  input wire logic system_reset_out,
  input wire logic system_reset_oe,
  input wire logic system_clock_out,
  input wire logic system_clock_oe,
  input wire logic muxed_addr_data_low_oe,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic reset_input_low,
  input wire logic pin_float_test_mode,
  input wire logic enhanced_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_in_out: assert property (reset_input_low |-> system_reset_out)
    else $error("reset output low while reset input is low");
  a_release_tail: assert property ($fell(reset_input_low) |-> system_reset_out [*4] ##1 !system_reset_out)
    else $error("reset output release not four clocks after input release");
  a_never_float: assert property (!pin_float_test_mode && !$past(pin_float_test_mode) |-> system_reset_oe)
    else $error("reset output floated outside test mode");
  a_enhanced_pick: assert property ($fell(reset_input_low) |->
    ##8 enhanced_mode == ($past(mode_strap_in, 9) && !$past(mode_strap_in, 1)))
    else $error("enhanced mode decision wrong");
  a_test_float: assert property (pin_float_test_mode && $past(pin_float_test_mode) |->
    !system_reset_oe && !system_clock_oe && !muxed_addr_data_low_oe && pin_oe == '0)
    else $error("pin driven in test mode");
  a_xtal_runs: assert property (ce |=> crystal_drive_out == $past(crystal_drive_in))
    else $error("crystal drive output stopped");
  a_ad_float: assert property (hold_ack || reset_input_low |=> !muxed_addr_data_low_oe)
    else $error("address data driven in hold or reset");
  a_clock_toggle: assert property (ce |=> system_clock_out != $past(system_clock_out))
    else $error("clock output did not toggle");
  a_test_entry: assert property ($fell(reset_input_low) |->
    pin_float_test_mode == !($past(upper_memory_select_in) || $past(lower_memory_select_in)))
    else $error("test mode entry wrong");
endmodule // rops_ctrl_sva
bind rops_ctrl rops_ctrl_sva #(.NUM_PINS(NUM_PINS)) u_sva (.clk, .rst, .ce, .hold_ack, .upper_memory_select_in,
  .lower_memory_select_in, .mode_strap_in, .crystal_drive_in, .crystal_drive_out, .system_reset_out,
  .system_reset_oe, .system_clock_out, .system_clock_oe, .muxed_addr_data_low_oe, .pin_oe, .reset_input_low,
  .pin_float_test_mode, .enhanced_mode);
`default_nettype wire

// ==== verif/rops_partner.sv ====
`default_nettype none
module rops_partner (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic sel_low,
  input wire logic loop_en,
  input wire logic system_reset_out,
  output wire logic external_reset_in_n,
  output wire logic mem_sel,
  output wire logic mode_strap_in,
  output logic [7:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign external_reset_in_n = !rst_req;
  // Selects are the inverse of sel_low and hold for the whole pass, well past the release sample.
  assign mem_sel = !sel_low;
  // Looped back, the strap is high at release and low once the reset output drops.
  assign mode_strap_in = loop_en ? system_reset_out : 1'b1;
  // Input data changes only off the sampling edge.
  always @(negedge clk) ad_in <= $urandom;
endmodule // rops_partner
`default_nettype wire

// ==== verif/reset_out_and_pin_state_ctrl_bench.sv ====
`include "rops_defines.vh"
`default_nettype none
module reset_out_and_pin_state_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rst_req = 1, sel_low = 0, loop_en = 0, hold_ack = 0, idle = 0, xtal = 0, ad_oe = 0;
  logic [7:0] ad_out = 8'h00;
  logic [3:0] cp_out = 4'h0, cp_oe = 4'h0;
  logic pd = 0;
  logic [7:0] ad_seen, ado_seen;
  logic [3:0] cp_seen;
  // Per-pin codes, pin 3 first, chosen so that every fixed code is driven somewhere.
  localparam logic [11:0] HOLD_M = {`ROPS_PM_FLOAT, `ROPS_PM_FLOAT, `ROPS_PM_HIGH, `ROPS_PM_LOW};
  localparam logic [11:0] RESET_M = {`ROPS_PM_WEAK_HIGH, `ROPS_PM_LOW, `ROPS_PM_FLOAT, `ROPS_PM_HIGH};
  wire ext_n, msel, strap, sro, sroe, sco, scoe, xo, adoe, ril, tmode, enh;
  wire [7:0] ad_in, ado, ads;
  wire [3:0] po, poe, pwh;
  int num_errors = 0, num_checks = 0, seed;
  always #50 clk = ~clk;
  rops_partner u_partner (.clk(clk), .rst_req(rst_req), .sel_low(sel_low), .loop_en(loop_en),
    .system_reset_out(sro), .external_reset_in_n(ext_n), .mem_sel(msel), .mode_strap_in(strap), .ad_in(ad_in));
  rops_ctrl #(.HOLD_MODES(HOLD_M), .RESET_MODES(RESET_M)) dut (.clk(clk), .rst(rst), .ce(1'b1),
    .external_reset_in_n(ext_n), .hold_ack(hold_ack),
    .idle_active(idle), .powerdown_active(pd), .upper_memory_select_in(msel), .lower_memory_select_in(msel),
    .mode_strap_in(strap), .crystal_drive_in(xtal), .core_ad_out(ad_out), .core_ad_oe(ad_oe),
    .muxed_addr_data_low_in(ad_in), .core_pin_out(cp_out), .core_pin_oe(cp_oe), .system_reset_out(sro),
    .system_reset_oe(sroe), .system_clock_out(sco), .system_clock_oe(scoe), .crystal_drive_out(xo),
    .muxed_addr_data_low_out(ado), .muxed_addr_data_low_oe(adoe), .ad_in_sampled(ads), .pin_out(po),
    .pin_oe(poe), .pin_weak_high(pwh), .reset_input_low(ril), .pin_float_test_mode(tmode), .enhanced_mode(enh));
  always @(negedge clk) begin
    xtal <= $urandom;
    ad_out <= $urandom;
    cp_out <= $urandom;
    idle <= $urandom;
  end
  // What the registered outputs should hold after each edge.
  always @(posedge clk) begin
    ad_seen <= ad_in;
    ado_seen <= ad_out;
    cp_seen <= cp_out;
  end
  // Pin results {weak, oe, out} for the fixed codes, which follow neither the core's drive nor the held state.
  function automatic logic [11:0] fixed_pins(input logic [11:0] modes);
    logic [2:0] r;
    fixed_pins = 12'h000;
    for (int i = 0; i < 4; i++) begin
      case (modes[i*3 +: 3])
        `ROPS_PM_HIGH: r = 3'b011;
        `ROPS_PM_LOW: r = 3'b010;
        `ROPS_PM_WEAK_HIGH: r = 3'b101;
        default: r = 3'b000;
      endcase
      fixed_pins[i] = r[0];
      fixed_pins[4 + i] = r[1];
      fixed_pins[8 + i] = r[2];
    end
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Clocks from the input release to the reset output drop: sync, strap sample, tail.
  function int rel_cycles();
    return 3 + `ROPS_RST_RELEASE_CYCLES;
  endfunction
  task run_reset(input logic sel, input logic loop);
    int cnt;
    logic [11:0] want;
    logic [3:0] keep_out, keep_oe;
    @(negedge clk);
    sel_low = sel;
    loop_en = loop;
    rst_req = 1;
    hold_ack = $urandom;
    ad_oe = 1;
    repeat (6 + $urandom % 10) @(negedge clk);
    check(sro, 1);
    check(sroe, 1);
    check(adoe, 0);
    want = fixed_pins(RESET_M);
    check(po, want[3:0]);
    check({pwh, poe}, want[11:4]);
    hold_ack = 0;
    rst_req = 0;
    cnt = 0;
    while (sro === 1'b1 && cnt < 40) begin
      @(negedge clk);
      cnt++;
    end
    check(cnt, rel_cycles());
    repeat (`ROPS_STRAP_LATE_CYCLES) @(negedge clk);
    check(enh, loop);
    check(tmode, sel);
    check(ads, ad_seen);
    if (sel) begin
      check({sroe, scoe, adoe, poe}, 8'h00);
    end else begin
      cp_oe = $urandom;
      hold_ack = 1;
      repeat (2) @(negedge clk);
      want = fixed_pins(HOLD_M);
      check({sro, sroe, adoe}, 8'h02);
      check(poe, want[7:4]);
      check({pwh, po}, {want[11:8], want[3:0]});
      hold_ack = 0;
      repeat (2) @(negedge clk);
      check({adoe, poe}, {1'b1, cp_oe});
      check({pwh, po}, {4'h0, cp_seen});
      check(ado, ado_seen);
      keep_out = cp_seen;
      keep_oe = cp_oe;
      pd = 1;
      cp_oe = ~cp_oe;
      repeat (3) @(negedge clk);
      check({poe, po}, {keep_oe, keep_out});
      pd = 0;
    end
  endtask
  task stop_test();
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    seed = $urandom(55);
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    for (int i = 0; i < 12; i++) run_reset(i == 1 || $urandom % 4 == 0, i == 2 || $urandom % 2 == 1);
    stop_test();
  end
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
endmodule // reset_out_and_pin_state_ctrl_bench
`default_nettype wire
